/* File: src/dsi3_framer_defs.vh */
// Constants for the command-and-response frame handler.
// Assumes inclusion by bare name from files in the same folder.
`ifndef DSI3_FRAMER_DEFS_VH
`define DSI3_FRAMER_DEFS_VH

// Frame layout, bit positions within the 32-bit message.
`define FRM_ADDR_MSB   31
`define FRM_ADDR_LSB   28
`define FRM_CMD_MSB    27
`define FRM_CMD_LSB    24
`define FRM_EXT_MSB    23
`define FRM_EXT_LSB    16
`define FRM_DATA_MSB   15
`define FRM_DATA_LSB   8
`define FRM_CRC_MSB    7
`define FRM_CRC_LSB    0
`define FRM_MSG_BITS   6'd32

// Check field: polynomial low terms and nondirect seed.
`define CRC_POLY       8'h2f
`define CRC_SEED       8'hff

// Command codes and the broadcast address.
`define CMD_REG_READ   4'h0
`define CMD_REG_WRITE  4'h8
`define CMD_ENTER_PDC  4'hb
`define ADDR_BROADCAST 4'h0

// Chip levels in units of the response current step.
`define CHIP_QUIESCENT 2'd0

// Chip duration and its cycle count at the 20 MHz system clock.
`define CLK_MHZ        20
`define CHIP_TIME_NS   3000
`define CHIP_CYCLES    ((`CHIP_TIME_NS * `CLK_MHZ) / 1000)

`endif

/* File: src/dsi3_cmd_resp_framer.v */
// Command check, response build and trilevel chip output for the
// command-and-response mode, plus the chip FIFO it feeds.
// Assumes a bit decoder on the same clock delivers command bits and a
// register array answers reads in the same cycle that the address is given.
//
// Contract
// - Command is address 4, command 4, extended byte 8, data 8, check 8.
// - Act only when frame address equals the configured physical address.
// - Check covers all 32 command bits, fed most significant bit first.
// - On check mismatch the command is dropped and nothing is sent.
// - Preset seed, shift message then check, accept only at all zeros.
// - Polynomial x8+x5+x3+x2+x+1, nondirect seed all ones, both ends.
// - Response is address, echoed command, two register bytes, check.
// - Response address field is the configured physical address.
// - Third field holds register at even base address plus one.
// - Fourth field holds register at even base address plus zero.
// - Each nibble becomes one symbol of three trilevel chips.
// - Chip 0 is quiescent, 1 adds one step, 2 adds two steps.
// - Nibble to chip triplets follow the fixed sixteen entry table.
// - Each symbol starts non-quiescent and holds a level change.
// - Response check over 32 bits, ones seed, eight zeros appended.
// - Codes 0 read, 8 write, b enter periodic mode; others reserved.
// - Reads to broadcast address zero or foreign addresses are ignored.
`timescale 1ns/1ps
`include "dsi3_framer_defs.vh"

// Synchronous FIFO with valid and ready on both sides.
module chip_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             i_sys_clk,
  input  wire             i_rst_b,
  input  wire [WIDTH-1:0] i_wr_data,
  input  wire             i_wr_valid,
  output wire             o_wr_ready,
  output wire [WIDTH-1:0] o_rd_data,
  output wire             o_rd_valid,
  input  wire             i_rd_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            do_wr;
  wire            do_rd;

  // Full and empty come from the occupancy count, never guessed.
  assign o_wr_ready = (count != DEPTH[AW:0]);
  assign o_rd_valid = (count != {(AW+1){1'b0}});
  assign o_rd_data  = mem[rd_ptr];
  assign do_wr      = i_wr_valid & o_wr_ready;
  assign do_rd      = i_rd_ready & o_rd_valid;

  // Storage writes need no reset; the pointers guard stale words.
  always @(posedge i_sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  // Pointers wrap at the depth; depth need not be a power of two.
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // chip_fifo

module dsi3_cmd_resp_framer #(
  parameter CHIP_CYC   = `CHIP_CYCLES,
  parameter FIFO_DEPTH = 16
) (
  input  wire       i_sys_clk,
  input  wire       i_rst_b,
  input  wire [3:0] i_phys_addr_cfg,
  input  wire       i_cmd_start,
  input  wire       i_cmd_bit,
  input  wire       i_cmd_bit_valid,
  input  wire [7:0] i_reg_rd_data,
  input  wire       i_tx_enable,
  output reg  [7:0] o_reg_rd_addr,
  output reg        o_reg_rd_en,
  output reg  [7:0] o_reg_wr_addr,
  output reg  [7:0] o_reg_wr_data,
  output reg        o_reg_wr_en,
  output reg        o_enter_periodic,
  output reg        o_cmd_accepted,
  output reg        o_crc_error,
  output reg        o_busy,
  output reg  [1:0] o_chip_level,
  output reg        o_tx_active
);
  localparam S_IDLE = 3'd0;
  localparam S_RDH  = 3'd1;
  localparam S_RDL  = 3'd2;
  localparam S_CRC  = 3'd3;
  localparam S_SEND = 3'd4;

  reg  [5:0]  rx_cnt;
  reg  [31:0] rx_shift;
  reg  [7:0]  rx_crc;
  reg         rx_done;
  reg  [2:0]  state;
  reg  [3:0]  rsp_cmd;
  reg  [7:0]  rsp_next_reg_byte;
  reg  [7:0]  rsp_base_byte;
  reg  [31:0] tx_word;
  reg  [7:0]  tx_crc;
  reg  [5:0]  tx_cnt;
  reg  [1:0]  chip_idx;
  reg  [15:0] chip_div;
  reg         chip_tick;
  wire [7:0]  next_rx_crc;
  wire [7:0]  next_tx_crc;
  wire [3:0]  frame_phys_addr;
  wire [3:0]  frame_cmd;
  wire [6:0]  reg_base_addr;
  wire [5:0]  symbol;
  wire        push_valid;
  wire        push_ready;
  wire [1:0]  fifo_chip;
  wire        fifo_valid;
  wire        fifo_take;

  // Serial check step: the new bit enters the low end, the top bit
  // folds the polynomial back in. Same step serves both directions.
  function [7:0] crc_step;
    input [7:0] crc;
    input       bit_in;
    begin
      crc_step = {crc[6:0], bit_in} ^ (crc[7] ? `CRC_POLY : 8'h00);
    end
  endfunction

  // Nibble to three chips, first chip in the top pair of bits.
  function [5:0] nib_to_symbol;
    input [3:0] nib;
    begin
      case (nib)
        4'h0: nib_to_symbol = {2'd1, 2'd1, 2'd0};
        4'h1: nib_to_symbol = {2'd2, 2'd1, 2'd1};
        4'h2: nib_to_symbol = {2'd1, 2'd0, 2'd2};
        4'h3: nib_to_symbol = {2'd2, 2'd0, 2'd2};
        4'h4: nib_to_symbol = {2'd1, 2'd0, 2'd0};
        4'h5: nib_to_symbol = {2'd2, 2'd1, 2'd2};
        4'h6: nib_to_symbol = {2'd1, 2'd1, 2'd2};
        4'h7: nib_to_symbol = {2'd2, 2'd0, 2'd1};
        4'h8: nib_to_symbol = {2'd2, 2'd2, 2'd0};
        4'h9: nib_to_symbol = {2'd2, 2'd1, 2'd0};
        4'ha: nib_to_symbol = {2'd1, 2'd2, 2'd2};
        4'hb: nib_to_symbol = {2'd2, 2'd2, 2'd1};
        4'hc: nib_to_symbol = {2'd1, 2'd2, 2'd0};
        4'hd: nib_to_symbol = {2'd2, 2'd0, 2'd0};
        4'he: nib_to_symbol = {2'd1, 2'd0, 2'd1};
        default: nib_to_symbol = {2'd1, 2'd2, 2'd1};
      endcase
    end
  endfunction

  assign next_rx_crc     = crc_step(rx_crc, i_cmd_bit);
  assign next_tx_crc     = crc_step(tx_crc, tx_word[31]);
  assign frame_phys_addr = rx_shift[`FRM_ADDR_MSB:`FRM_ADDR_LSB];
  assign frame_cmd       = rx_shift[`FRM_CMD_MSB:`FRM_CMD_LSB];
  assign reg_base_addr   = rx_shift[`FRM_EXT_MSB:`FRM_EXT_LSB+1];
  assign symbol          = nib_to_symbol(tx_word[31:28]);
  assign push_valid      = (state == S_SEND);
  assign fifo_take       = chip_tick & i_tx_enable;

  // Receive: seed on frame start, shift 32 bits in arrival order, the
  // first bit being the address MSB and the check field coming last.
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rx_cnt   <= 6'd0;
      rx_shift <= 32'h0000_0000;
      rx_crc   <= `CRC_SEED;
      rx_done  <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (i_cmd_start) begin
        rx_cnt <= 6'd0;
        rx_crc <= `CRC_SEED;
      end else if (i_cmd_bit_valid && rx_cnt != `FRM_MSG_BITS) begin
        rx_shift <= {rx_shift[30:0], i_cmd_bit};
        rx_crc   <= next_rx_crc;
        rx_cnt   <= rx_cnt + 6'd1;
        rx_done  <= (rx_cnt == `FRM_MSG_BITS - 6'd1);
      end
    end
  end

  // Chip rate divider: one enable pulse per chip time.
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      chip_div  <= 16'h0000;
      chip_tick <= 1'b0;
    end else begin
      chip_tick <= (chip_div == CHIP_CYC[15:0] - 16'h0001);
      if (chip_div == CHIP_CYC[15:0] - 16'h0001) begin
        chip_div <= 16'h0000;
      end else begin
        chip_div <= chip_div + 16'h0001;
      end
    end
  end

  // Frame decode, register fetch, response check and symbol push.
  // A command that completes while a response is still being built is
  // dropped; the master is expected to wait for the answer.
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state             <= S_IDLE;
      rsp_cmd           <= 4'h0;
      rsp_next_reg_byte <= 8'h00;
      rsp_base_byte     <= 8'h00;
      tx_word           <= 32'h0000_0000;
      tx_crc            <= `CRC_SEED;
      tx_cnt            <= 6'd0;
      chip_idx          <= 2'd0;
      o_reg_rd_addr     <= 8'h00;
      o_reg_rd_en       <= 1'b0;
      o_reg_wr_addr     <= 8'h00;
      o_reg_wr_data     <= 8'h00;
      o_reg_wr_en       <= 1'b0;
      o_enter_periodic  <= 1'b0;
      o_cmd_accepted    <= 1'b0;
      o_crc_error       <= 1'b0;
      o_busy            <= 1'b0;
    end else begin
      o_reg_rd_en      <= 1'b0;
      o_reg_wr_en      <= 1'b0;
      o_enter_periodic <= 1'b0;
      o_cmd_accepted   <= 1'b0;
      o_crc_error      <= 1'b0;
      case (state)
        S_IDLE: begin
          o_busy <= 1'b0;
          if (rx_done && rx_crc != 8'h00) begin
            o_crc_error <= 1'b1;
          end else if (rx_done && frame_phys_addr == i_phys_addr_cfg
                       && frame_phys_addr != `ADDR_BROADCAST) begin
            rsp_cmd <= frame_cmd;
            if (frame_cmd == `CMD_REG_READ ||
                frame_cmd == `CMD_REG_WRITE) begin
              o_cmd_accepted <= 1'b1;
              o_busy         <= 1'b1;
              o_reg_rd_addr  <= {reg_base_addr, 1'b1};
              o_reg_rd_en    <= 1'b1;
              state          <= S_RDH;
              if (frame_cmd == `CMD_REG_WRITE) begin
                o_reg_wr_addr <= rx_shift[`FRM_EXT_MSB:`FRM_EXT_LSB];
                o_reg_wr_data <= rx_shift[`FRM_DATA_MSB:`FRM_DATA_LSB];
                o_reg_wr_en   <= 1'b1;
              end
            end else if (frame_cmd == `CMD_ENTER_PDC) begin
              o_cmd_accepted   <= 1'b1;
              o_enter_periodic <= 1'b1;
            end
          end
        end
        S_RDH: begin
          rsp_next_reg_byte <= i_reg_rd_data;
          o_reg_rd_addr     <= {o_reg_rd_addr[7:1], 1'b0};
          o_reg_rd_en       <= 1'b1;
          state             <= S_RDL;
        end
        S_RDL: begin
          rsp_base_byte <= i_reg_rd_data;
          tx_word <= {i_phys_addr_cfg, rsp_cmd, rsp_next_reg_byte,
                      i_reg_rd_data, 8'h00};
          tx_crc  <= `CRC_SEED;
          tx_cnt  <= 6'd0;
          state   <= S_CRC;
        end
        S_CRC: begin
          // 24 message bits, then the zeroed check field as the eight
          // appended zeros, one per cycle.
          tx_crc  <= next_tx_crc;
          tx_word <= {tx_word[30:0], 1'b0};
          tx_cnt  <= tx_cnt + 6'd1;
          if (tx_cnt == `FRM_MSG_BITS - 6'd1) begin
            tx_word  <= {i_phys_addr_cfg, rsp_cmd, rsp_next_reg_byte,
                         rsp_base_byte, next_tx_crc};
            tx_cnt   <= 6'd0;
            chip_idx <= 2'd0;
            state    <= S_SEND;
          end
        end
        S_SEND: begin
          // Three chips per nibble, top nibble first; waits on FIFO room.
          if (push_ready) begin
            if (chip_idx == 2'd2) begin
              chip_idx <= 2'd0;
              tx_word  <= {tx_word[27:0], 4'h0};
              tx_cnt   <= tx_cnt + 6'd1;
              if (tx_cnt == 6'd7) begin
                state <= S_IDLE;
              end
            end else begin
              chip_idx <= chip_idx + 2'd1;
            end
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  chip_fifo #(
    .WIDTH (2),
    .DEPTH (FIFO_DEPTH),
    .AW    (4)
  ) u_chip_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_wr_data  ((chip_idx == 2'd0) ? symbol[5:4] :
                 (chip_idx == 2'd1) ? symbol[3:2] : symbol[1:0]),
    .i_wr_valid (push_valid),
    .o_wr_ready (push_ready),
    .o_rd_data  (fifo_chip),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_take)
  );

  // Line driver: one chip per tick; quiescent once the FIFO runs dry.
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      o_chip_level <= `CHIP_QUIESCENT;
      o_tx_active  <= 1'b0;
    end else if (fifo_take) begin
      o_chip_level <= fifo_valid ? fifo_chip : `CHIP_QUIESCENT;
      o_tx_active  <= fifo_valid;
    end
  end
endmodule // dsi3_cmd_resp_framer

/* File: verif/dsi3_master_model.sv */
// Bus master model: sends one command frame per request, MSB first.
// Assumes the framer's clock; the caller waits for o_busy to fall.
`timescale 1ns/1ps
module dsi3_master_model (
  input  wire logic        i_sys_clk,
  input  wire logic        i_go,
  input  wire logic [23:0] i_msg,
  input  wire logic        i_bad,
  output logic             o_start,
  output logic             o_bit,
  output logic             o_valid,
  output logic             o_busy
);
  logic [31:0] shift;
  int          left;

  // Seeded register, message bits then eight zeros, poly low bits 2f.
  function automatic logic [7:0] crc8(input logic [23:0] m);
    logic [7:0] c;
    logic       fb;
    c = 8'hff;
    for (int i = 0; i < 32; i++) begin
      fb = c[7];
      c = {c[6:0], (i < 24) ? m[23-i] : 1'b0};
      if (fb) c = c ^ 8'h2f;
    end
    return c;
  endfunction

  initial begin
    o_start = 1'b0;
    o_bit = 1'b0;
    o_valid = 1'b0;
    o_busy = 1'b0;
    left = 0;
  end

  // The data line toggles when idle so a stale bit is never mistaken.
  always @(posedge i_sys_clk) begin
    o_start <= 1'b0;
    o_valid <= 1'b0;
    if (i_go && !o_busy) begin
      o_start <= 1'b1;
      shift <= {i_msg, crc8(i_msg) ^ {7'd0, i_bad}};
      left <= 32;
      o_busy <= 1'b1;
      o_bit <= ~o_bit;
    end else if (left > 0) begin
      o_valid <= 1'b1;
      o_bit <= shift[31];
      shift <= {shift[30:0], 1'b0};
      left <= left - 1;
    end else begin
      o_busy <= 1'b0;
      o_bit <= ~o_bit;
    end
  end
endmodule // dsi3_master_model

/* File: verif/framer_props.sv */
// Port checker for the command-and-response framer.
// Assumes it is bound onto the framer top and sees only its ports.
`timescale 1ns/1ps
module framer_props (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_b,
  input wire logic       i_tx_enable,
  input wire logic [7:0] o_reg_rd_addr,
  input wire logic       o_reg_rd_en,
  input wire logic       o_reg_wr_en,
  input wire logic       o_enter_periodic,
  input wire logic       o_cmd_accepted,
  input wire logic       o_crc_error,
  input wire logic       o_busy,
  input wire logic [1:0] o_chip_level,
  input wire logic       o_tx_active
);
  // One clock domain, so one clock and one reset serve all properties.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  idle_quiet_a: assert property (!o_tx_active |-> o_chip_level == 2'd0)
    else $error("chip level not quiescent while idle");
  level_legal_a: assert property (o_chip_level != 2'd3)
    else $error("chip level outside three levels");
  crc_drop_a: assert property (o_crc_error |-> !(o_cmd_accepted ||
    o_reg_rd_en || o_reg_wr_en || o_enter_periodic))
    else $error("bad check frame still acted on");
  read_pair_a: assert property (o_cmd_accepted && o_reg_rd_en |->
    o_reg_rd_addr[0] ##1 o_reg_rd_en &&
    o_reg_rd_addr == {$past(o_reg_rd_addr[7:1]), 1'b0})
    else $error("register pair read order wrong");
  accept_busy_a: assert property (
    o_cmd_accepted && o_reg_rd_en |-> o_busy)
    else $error("accepted read without response build");
  write_read_a: assert property (
    o_reg_wr_en |-> o_cmd_accepted && o_reg_rd_en)
    else $error("write without accept and readback");
  periodic_only_a: assert property (o_enter_periodic |-> o_cmd_accepted &&
    !o_reg_rd_en && !o_reg_wr_en)
    else $error("periodic entry mixed with register access");
  sym_start_a: assert property ($rose(o_tx_active) |->
    o_chip_level != 2'd0 && $past(i_tx_enable))
    else $error("response start quiescent or while stalled");

  cover property (o_crc_error);
  cover property (o_reg_wr_en);
  cover property ($rose(o_tx_active));
endmodule // framer_props

bind dsi3_cmd_resp_framer framer_props u_props (.i_sys_clk, .i_rst_b,
  .i_tx_enable, .o_reg_rd_addr, .o_reg_rd_en, .o_reg_wr_en,
  .o_enter_periodic, .o_cmd_accepted, .o_crc_error, .o_busy,
  .o_chip_level, .o_tx_active);

/* File: verif/tb.sv */
// Self-checking bench: master model, register array and response model.
// Assumes the framer runs with a four-cycle chip for short runs.
`timescale 1ns/1ps
module tb;
  localparam int CHIP = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  cfg = 4'h0;
  logic        tx_en = 1'b0;
  logic [7:0]  rd_data;
  logic [3:0]  keep_cfg;
  logic        go = 1'b0;
  logic [23:0] msg = 24'h0;
  logic        bad = 1'b0;
  logic        cmd_start, cmd_bit, cmd_valid, m_busy;
  logic [7:0]  rd_addr, wr_addr, wr_data;
  logic        rd_en, wr_en, periodic, accepted, crc_err, busy, tx_act;
  logic [1:0]  level;
  logic [7:0]  mem [256];
  logic [7:0]  emem [256];
  int          mismatches = 0, samples_checked = 0, cc = 0;
  int          acc_n = 0, err_n = 0, per_n = 0;
  int          exp_acc = 0, exp_err = 0, exp_per = 0;
  int          expq[$];
  bit          was_act = 0;
  string       sym = "110211102202100212112201220210122221120200101121";

  initial forever #25 clk = ~clk;

  dsi3_cmd_resp_framer #(.CHIP_CYC(CHIP), .FIFO_DEPTH(16)) dut (
    .i_sys_clk(clk), .i_rst_b(rst_b), .i_phys_addr_cfg(cfg),
    .i_cmd_start(cmd_start), .i_cmd_bit(cmd_bit),
    .i_cmd_bit_valid(cmd_valid), .i_reg_rd_data(rd_data),
    .i_tx_enable(tx_en), .o_reg_rd_addr(rd_addr), .o_reg_rd_en(rd_en),
    .o_reg_wr_addr(wr_addr), .o_reg_wr_data(wr_data),
    .o_reg_wr_en(wr_en), .o_enter_periodic(periodic),
    .o_cmd_accepted(accepted), .o_crc_error(crc_err), .o_busy(busy),
    .o_chip_level(level), .o_tx_active(tx_act));

  dsi3_master_model u_master (.i_sys_clk(clk), .i_go(go), .i_msg(msg),
    .i_bad(bad), .o_start(cmd_start), .o_bit(cmd_bit),
    .o_valid(cmd_valid), .o_busy(m_busy));

  // Register array: the framer samples the answer at the edge that ends
  // its read strobe, so reads answer at once from the address; a write
  // in the same cycle is forwarded, and idle reads show the inverse.
  always @(posedge clk) begin
    if (wr_en === 1'b1) mem[wr_addr] <= wr_data;
  end
  assign rd_data = (rd_en !== 1'b1) ? ~mem[rd_addr] :
                   (wr_en === 1'b1 && wr_addr == rd_addr) ? wr_data
                                                          : mem[rd_addr];

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Count pulses and take one chip sample per chip time while active.
  always @(negedge clk) begin
    if (rst_b) begin
      if (accepted === 1'b1) acc_n++;
      if (crc_err === 1'b1) err_n++;
      if (periodic === 1'b1) per_n++;
      if (tx_act === 1'b1 && (!was_act || cc == CHIP)) begin
        cc = 1;
        if (expq.size() == 0) chk("chip_extra", 0, 1);
        else chk("chip_level", expq.pop_front(), {30'd0, level});
      end else cc++;
      was_act = (tx_act === 1'b1);
    end
  end

  // Reference behaviour: decide the outcome and queue expected chips.
  task automatic model(input logic [3:0] a, input logic [3:0] c,
                       input logic [7:0] e, input logic [7:0] d,
                       input bit b, output bit resp);
    logic [31:0] w;
    logic [7:0]  base;
    resp = 0;
    if (b) begin
      exp_err++;
      return;
    end
    if (a != cfg || a == 4'h0) return;
    if (c == 4'hb) begin
      exp_acc++;
      exp_per++;
      return;
    end
    if (c != 4'h0 && c != 4'h8) return;
    exp_acc++;
    resp = 1;
    if (c == 4'h8) emem[e] = d;
    base = {e[7:1], 1'b0};
    w[31:8] = {cfg, c, emem[base | 8'h01], emem[base]};
    w[7:0] = u_master.crc8(w[31:8]);
    for (int n = 7; n >= 0; n--)
      for (int j = 0; j < 3; j++)
        expq.push_back(sym[w[n*4+:4]*3+j] - "0");
  endtask

  // One frame with the line stalled long enough to fill the buffer.
  task automatic frame(input string name, input logic [3:0] a,
                       input logic [3:0] c, input bit b);
    logic [7:0] e, d;
    bit         resp;
    int         n;
    e = 8'($urandom);
    d = 8'($urandom);
    model(a, c, e, d, b, resp);
    @(posedge clk);
    tx_en <= 1'b0;
    go <= 1'b1;
    msg <= {a, c, e, d};
    bad <= b;
    @(posedge clk);
    go <= 1'b0;
    repeat (150) @(posedge clk);
    @(negedge clk);
    chk("busy_stalled", {31'd0, resp}, {31'd0, busy});
    @(posedge clk);
    tx_en <= 1'b1;
    n = 0;
    while ((expq.size() != 0 || busy !== 1'b0 || tx_act !== 1'b0)
           && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("drain_done", 1, {31'd0, n < 1000});
    chk("accepted", exp_acc, acc_n);
    chk("crc_error", exp_err, err_n);
    chk("periodic", exp_per, per_n);
    $display("test %s code %0h done", name, c);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence; the periodic-entry code runs last in the code sweep.
  initial begin
    void'($urandom(58444));
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($urandom);
      emem[i] = mem[i];
    end
    cfg <= 4'($urandom_range(7, 1));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset_state", 0, {28'd0, busy, tx_act, level});
    frame("bad_check", cfg, 4'h0, 1'b1);
    frame("foreign_addr", cfg ^ 4'h8, 4'h0, 1'b0);
    // A zero configured address must still refuse the broadcast address.
    keep_cfg = cfg;
    cfg <= 4'h0;
    @(posedge clk);
    frame("broadcast_read", 4'h0, 4'h0, 1'b0);
    frame("broadcast_write", 4'h0, 4'h8, 1'b0);
    cfg <= keep_cfg;
    @(posedge clk);
    for (int c = 0; c < 16; c++)
      frame("code", cfg, 4'(c + 12), 1'b0);
    finish_test();
  end

  // Watchdog sized well above twenty stalled frames.
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    finish_test();
  end
endmodule // tb
